// File: include/dco_pkg.sv
package dco_pkg;
  // Overlay word positions
  localparam logic [7:0] IDX_REV = 8'h00;
  localparam logic [7:0] IDX_UDMA = 8'h02;
  localparam logic [7:0] IDX_LBA0 = 8'h03;
  localparam logic [7:0] IDX_LBA3 = 8'h06;
  localparam logic [7:0] IDX_FEAT = 8'h07;
  localparam logic [7:0] IDX_LAST = 8'hff;
  localparam logic [15:0] REV_VALUE = 16'h0001;
  localparam logic [7:0] SIGNATURE = 8'ha5;
  // Diagnostic values for the cylinder-high register
  localparam logic [7:0] CYLH_REV = 8'h00;
  localparam logic [7:0] CYLH_CKSUM = 8'hff;
  // Task-file values
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam logic [7:0] STAT_OK = 8'h50;
  localparam logic [7:0] STAT_ERR = 8'h51;
  localparam logic [7:0] STAT_BUSY = 8'h80;
  localparam logic [7:0] ERR_RST = 8'h01;
  localparam logic [7:0] SECN_RST = 8'h01;
  localparam logic [7:0] STAT_RST = 8'h50;
  // Field layouts of the overlay words
  localparam int unsigned UDMA_W = 6;
  localparam int unsigned FEAT_W = 9;
  localparam logic [27:0] LBA28_MAX = 28'hfffffff;
  // Reset values of the identify words, every optional feature present
  localparam logic [15:0] W82_RST = 16'h0403;
  localparam logic [15:0] W83_RST = 16'h0762;
  localparam logic [15:0] W84_RST = 16'h0003;
  localparam logic [15:0] W88_RST = 16'h003f;
  localparam logic [15:0] W94_RST = 16'h8080;

  typedef struct packed {
    logic [15:0] w60;
    logic [15:0] w61;
    logic [15:0] w82;
    logic [15:0] w83;
    logic [15:0] w84;
    logic [15:0] w85;
    logic [15:0] w86;
    logic [15:0] w87;
    logic [15:0] w88;
    logic [15:0] w94;
    logic [15:0] w100;
    logic [15:0] w101;
    logic [15:0] w102;
    logic [15:0] w103;
  } dco_ident_s;

  typedef struct packed {
    logic supported;
    logic freeze_lock;
    logic hpa_set;
    logic security_on;
    logic standby_jumper;
    logic smart_on;
    logic udma_sel_valid;
    logic [2:0] udma_sel;
  } dco_cond_s;

  typedef struct packed {
    logic busy;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
  } dco_taskfile_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_EVAL = 2'b11,
    ST_DONE = 2'b10
  } dco_state_e;
endpackage : dco_pkg

// File: rtl/dco_checker.sv
module dco_checker
  import dco_pkg::*;
#(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_0100_0000
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_START,
  input wire logic I_WORD_VALID,
  input wire logic [15:0] I_WORD,
  input wire dco_pkg::dco_cond_s I_COND,
  output dco_pkg::dco_taskfile_s O_TASKFILE,
  output logic O_DONE,
  output dco_pkg::dco_ident_s O_IDENT,
  output logic [47:0] O_MAX_LBA
);
  import dco_pkg::*;

  localparam dco_ident_s IDENT_RST = '{
    w60: (NATIVE_MAX > 48'h0fff_ffff) ? 16'hffff : NATIVE_MAX[15:0],
    w61: (NATIVE_MAX > 48'h0fff_ffff) ? 16'h0fff : {4'h0, NATIVE_MAX[27:16]},
    w82: W82_RST,
    w83: W83_RST,
    w84: W84_RST,
    w85: W82_RST,
    w86: W83_RST,
    w87: W84_RST,
    w88: W88_RST,
    w94: W94_RST,
    w100: NATIVE_MAX[15:0],
    w101: NATIVE_MAX[31:16],
    w102: NATIVE_MAX[47:32],
    w103: 16'h0000
  };

  dco_state_e state;
  dco_state_e next_state;
  logic [7:0] idx;
  logic [7:0] sum;
  logic [15:0] ovl_rev;
  logic [15:0] ovl_udma;
  logic [63:0] ovl_lba;
  logic [15:0] ovl_feat;
  logic [7:0] sig;
  logic modified;

  // Word intake
  logic take;
  logic last_word;
  logic [7:0] next_sum;
  assign take = (state == ST_RECV) && I_WORD_VALID;
  assign last_word = take && (idx == IDX_LAST);
  assign next_sum = sum + I_WORD[15:8] + I_WORD[7:0];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (I_START) begin
          next_state = ST_RECV;
        end
      end
      ST_RECV: begin
        if (last_word) begin
          next_state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
      idx <= 8'h00;
      sum <= 8'h00;
    end else begin
      state <= next_state;
      if (state == ST_IDLE) begin
        idx <= 8'h00;
        sum <= 8'h00;
      end else if (take) begin
        idx <= idx + 8'h01;
        sum <= next_sum;
      end
    end
  end

  // Only the handful of words that carry meaning are kept
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ovl_rev <= 16'h0000;
      ovl_udma <= 16'h0000;
      ovl_lba <= 64'h0;
      ovl_feat <= 16'h0000;
      sig <= 8'h00;
    end else if (take) begin
      if (idx == IDX_REV) begin
        ovl_rev <= I_WORD;
      end
      if (idx == IDX_UDMA) begin
        ovl_udma <= I_WORD;
      end
      if (idx >= IDX_LBA0 && idx <= IDX_LBA3) begin
        ovl_lba <= {I_WORD, ovl_lba[63:16]};
      end
      if (idx == IDX_FEAT) begin
        ovl_feat <= I_WORD;
      end
      if (idx == IDX_LAST) begin
        sig <= I_WORD[7:0];
      end
    end
  end

  // Current capabilities seen through the identify words
  logic [UDMA_W-1:0] cur_udma;
  logic [FEAT_W-1:0] cap;
  assign cur_udma = O_IDENT.w88[UDMA_W-1:0];
  assign cap = {O_IDENT.w83[10], O_IDENT.w82[10], O_IDENT.w83[9], O_IDENT.w83[1],
                O_IDENT.w83[5], O_IDENT.w82[1], O_IDENT.w84[0], O_IDENT.w84[1],
                O_IDENT.w82[0]};

  logic [UDMA_W-1:0] udma_refused;
  logic [UDMA_W-1:0] udma_next;
  dco_ladder_chk #(
    .W(UDMA_W)
  ) u_udma (
    .i_cur(cur_udma),
    .i_ovl(ovl_udma[UDMA_W-1:0]),
    .i_sel_valid(I_COND.udma_sel_valid),
    .i_sel(I_COND.udma_sel),
    .o_refused(udma_refused),
    .o_next(udma_next)
  );

  logic [FEAT_W-1:0] fovl;
  logic [FEAT_W-1:0] fkept;
  logic [FEAT_W-1:0] fclr;
  logic [FEAT_W-1:0] feat_refused;
  assign fovl = ovl_feat[FEAT_W-1:0];
  assign fkept = cap & fovl;
  assign fclr = cap & ~fovl;
  assign feat_refused[7] = fclr[7] & I_COND.hpa_set;
  assign feat_refused[3] = fclr[3] & I_COND.security_on;
  assign feat_refused[0] = fclr[0] & (fkept[1] | fkept[2] | I_COND.smart_on);
  assign feat_refused[8] = 1'b0;
  assign feat_refused[6:4] = 3'b000;
  assign feat_refused[2:1] = 2'b00;

  logic clr_standby;
  assign clr_standby = fclr[4] & ~I_COND.standby_jumper;

  logic [47:0] new_lba;
  logic lba_changed;
  logic lba_bad;
  assign new_lba = ovl_lba[47:0];
  assign lba_changed = (ovl_lba != {16'h0000, O_MAX_LBA});
  assign lba_bad = lba_changed &
                   (I_COND.hpa_set | (ovl_lba[63:48] != 16'h0000) | (new_lba > NATIVE_MAX));

  logic gate_bad;
  logic rev_bad;
  logic cksum_bad;
  assign gate_bad = ~I_COND.supported | I_COND.freeze_lock | modified;
  assign rev_bad = (ovl_rev != REV_VALUE);
  assign cksum_bad = (sig != SIGNATURE) | (sum != 8'h00);

  // abort decision uses every word before anything is applied
  logic abort;
  logic [15:0] refused_bits;
  logic [7:0] cyl_hi_code;
  always_comb begin
    abort = 1'b1;
    refused_bits = 16'h0000;
    cyl_hi_code = 8'h00;
    if (gate_bad) begin
      cyl_hi_code = 8'h00;
    end else if (rev_bad) begin
      cyl_hi_code = CYLH_REV;
    end else if (cksum_bad) begin
      cyl_hi_code = CYLH_CKSUM;
    end else if (|udma_refused) begin
      refused_bits = {{(16 - UDMA_W){1'b0}}, udma_refused};
      cyl_hi_code = IDX_UDMA;
    end else if (lba_bad) begin
      cyl_hi_code = IDX_LBA0;
    end else if (|feat_refused) begin
      refused_bits = {{(16 - FEAT_W){1'b0}}, feat_refused};
      cyl_hi_code = IDX_FEAT;
    end else begin
      abort = 1'b0;
    end
  end

  // Identify words after a successful overlay
  dco_ident_s next_ident;
  logic [27:0] lba28;
  assign lba28 = (new_lba > {20'h0, LBA28_MAX}) ? LBA28_MAX : new_lba[27:0];
  always_comb begin
    next_ident = O_IDENT;
    next_ident.w88 = {O_IDENT.w88[15:UDMA_W], udma_next};
    next_ident.w60 = lba28[15:0];
    next_ident.w61 = {4'h0, lba28[27:16]};
    next_ident.w100 = new_lba[15:0];
    next_ident.w101 = new_lba[31:16];
    next_ident.w102 = new_lba[47:32];
    next_ident.w103 = 16'h0000;
    if (fclr[8]) begin
      next_ident.w83[10] = 1'b0;
      next_ident.w86[10] = 1'b0;
      next_ident.w100 = 16'h0000;
      next_ident.w101 = 16'h0000;
      next_ident.w102 = 16'h0000;
    end
    if (fclr[7]) begin
      next_ident.w82[10] = 1'b0;
      next_ident.w85[10] = 1'b0;
      next_ident.w83[8] = 1'b0;
      next_ident.w86[8] = 1'b0;
    end
    if (fclr[6]) begin
      next_ident.w83[9] = 1'b0;
      next_ident.w94 = 16'h0000;
    end
    if (fclr[5]) begin
      next_ident.w83[1] = 1'b0;
      next_ident.w86[1] = 1'b0;
    end
    if (clr_standby) begin
      next_ident.w83[6:5] = 2'b00;
      next_ident.w86[6:5] = 2'b00;
      next_ident.w94 = 16'h0000;
    end
    if (fclr[3]) begin
      next_ident.w82[1] = 1'b0;
      next_ident.w85[1] = 1'b0;
    end
    if (fclr[2]) begin
      next_ident.w84[0] = 1'b0;
      next_ident.w87[0] = 1'b0;
    end
    if (fclr[1]) begin
      next_ident.w84[1] = 1'b0;
      next_ident.w87[1] = 1'b0;
    end
    if (fclr[0]) begin
      next_ident.w82[0] = 1'b0;
      next_ident.w85[0] = 1'b0;
    end
  end

  logic apply;
  assign apply = (state == ST_EVAL) && !abort;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_IDENT <= IDENT_RST;
      O_MAX_LBA <= NATIVE_MAX;
      modified <= 1'b0;
    end else if (apply) begin
      O_IDENT <= next_ident;
      O_MAX_LBA <= new_lba;
      modified <= 1'b1;
    end
  end

  dco_taskfile_s next_tf;
  always_comb begin
    next_tf = O_TASKFILE;
    if (state == ST_IDLE && I_START) begin
      next_tf.busy = 1'b1;
      next_tf.status = STAT_BUSY;
    end else if (state == ST_EVAL) begin
      next_tf.busy = 1'b0;
      next_tf.status = abort ? STAT_ERR : STAT_OK;
      next_tf.error = abort ? ERR_ABRT : 8'h00;
      next_tf.sec_num = refused_bits[7:0];
      next_tf.cyl_lo = refused_bits[15:8];
      next_tf.cyl_hi = abort ? cyl_hi_code : 8'h00;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_TASKFILE <= '{busy: 1'b0, status: STAT_RST, error: ERR_RST, sec_num: SECN_RST,
                      cyl_lo: 8'h00, cyl_hi: 8'h00};
      O_DONE <= 1'b0;
    end else begin
      O_TASKFILE <= next_tf;
      O_DONE <= (state == ST_EVAL);
    end
  end
endmodule : dco_checker

// File: rtl/dco_ladder_chk.sv
module dco_ladder_chk #(
  parameter int unsigned W = 6
) (
  input wire logic [W-1:0] i_cur,
  input wire logic [W-1:0] i_ovl,
  input wire logic i_sel_valid,
  input wire logic [2:0] i_sel,
  output logic [W-1:0] o_refused,
  output logic [W-1:0] o_next
);
  logic [W-1:0] kept;
  assign kept = i_cur & i_ovl;
  assign o_next = kept;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic clr;
      logic higher;
      logic sel_hi;
      assign clr = i_cur[g] & ~i_ovl[g];
      if (g == W - 1) begin : g_top
        assign higher = 1'b0;
      end else begin : g_mid
        assign higher = |kept[W-1:g+1];
      end
      assign sel_hi = i_sel_valid && (i_sel >= 3'(g));
      assign o_refused[g] = clr & (higher | sel_hi);
    end
  endgenerate
endmodule : dco_ladder_chk

// File: sim/dco_checker_bench.sv
module dco_checker_bench
  import dco_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] NAT = 48'h0000_0100_0000;
  localparam logic [63:0] LD = {16'h0, NAT};
  localparam logic [63:0] LN = 64'h80_0000;
  logic clock, rstn, go, bad, slow, start, valid, done;
  logic [15:0] rev, udma, feat, word;
  logic [63:0] lba;
  logic [47:0] maxl, pl;
  dco_cond_s cond;
  dco_taskfile_s tf;
  dco_ident_s id, pre;
  int err_total = 0;
  int samples_checked = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end

  dco_checker #(.NATIVE_MAX(NAT)) dco_checker_i (.I_CLOCK(clock), .I_RSTN(rstn),
    .I_START(start), .I_WORD_VALID(valid), .I_WORD(word), .I_COND(cond),
    .O_TASKFILE(tf), .O_DONE(done), .O_IDENT(id), .O_MAX_LBA(maxl));
  dco_host_model dco_host_model_i (.i_clock(clock), .i_go(go), .i_slow(slow),
    .i_bad_sum(bad), .i_rev(rev), .i_udma(udma), .i_lba(lba), .i_feat(feat),
    .o_start(start), .o_valid(valid), .o_word(word));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // Condition word: {supported, freeze, hpa, security, jumper, smart, sel_valid, sel}
  task automatic run(input logic [15:0] r, input logic [15:0] u, input logic [63:0] l,
      input logic [15:0] f, input logic b, input logic [9:0] c);
    int n;
    @(negedge clock);
    pre = id;
    pl = maxl;
    cond = dco_cond_s'(c);
    rev = r;
    udma = u;
    lba = l;
    feat = f;
    bad = b;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    // A command that never completes counts as a mismatch
    `CHK("done", 1'b1, done)
  endtask : run

  task automatic abrt(input logic [7:0] hi, input logic [7:0] sn);
    `CHK("status", STAT_ERR, tf.status)
    `CHK("error", ERR_ABRT, tf.error)
    `CHK("cyl_hi", hi, tf.cyl_hi)
    `CHK("sec_num", sn, tf.sec_num)
    `CHK("cyl_lo", 8'h00, tf.cyl_lo)
    `CHK("ident", pre, id)
    `CHK("max_lba", pl, maxl)
  endtask : abrt

  initial begin
    #100000;
    err_total++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    go = 1'b0;
    bad = 1'b0;
    slow = 1'b1;
    rev = 16'h0;
    udma = 16'h0;
    lba = 64'h0;
    feat = 16'h0;
    cond = '0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    `CHK("status", STAT_RST, tf.status)
    `CHK("w88", W88_RST, id.w88)
    `CHK("max_lba", NAT, maxl)
    run(16'h0002, 16'h003f, LD, 16'h01ff, 1'b0, 10'h200);
    abrt(CYLH_REV, 8'h00);
    slow = 1'b0;
    run(REV_VALUE, 16'h003f, LD, 16'h01ff, 1'b1, 10'h200);
    abrt(CYLH_CKSUM, 8'h00);
    run(REV_VALUE, 16'h001f, LD, 16'h01ff, 1'b0, 10'h20d);
    abrt(8'h02, 8'h20);
    run(REV_VALUE, 16'h002f, LD, 16'h01ff, 1'b0, 10'h20b);
    abrt(8'h02, 8'h10);
    run(REV_VALUE, 16'h003d, LD, 16'h01ff, 1'b0, 10'h200);
    abrt(8'h02, 8'h02);
    run(REV_VALUE, 16'h003f, LD, 16'h01f7, 1'b0, 10'h240);
    abrt(8'h07, 8'h08);
    run(REV_VALUE, 16'h003f, LD, 16'h01fe, 1'b0, 10'h200);
    abrt(8'h07, 8'h01);
    run(REV_VALUE, 16'h003f, LN, 16'h01ff, 1'b0, 10'h280);
    abrt(8'h03, 8'h00);
    run(REV_VALUE, 16'h003f, LD, 16'h01ff, 1'b0, 10'h300);
    abrt(CYLH_REV, 8'h00);
    run(REV_VALUE, 16'h003f, LD, 16'h01ff, 1'b0, 10'h000);
    abrt(CYLH_REV, 8'h00);
    // Reserved bits set, jumper holds standby support
    run(REV_VALUE, 16'hffc7, LN, 16'hfe09, 1'b0, 10'h22a);
    `CHK("status", STAT_OK, tf.status)
    `CHK("w88", 16'h0007, id.w88)
    `CHK("w83", 16'h0060, id.w83)
    `CHK("w86", 16'h0260, id.w86)
    `CHK("w82", 16'h0003, id.w82)
    `CHK("w85", 16'h0003, id.w85)
    `CHK("w84", 16'h0000, id.w84)
    `CHK("w87", 16'h0000, id.w87)
    `CHK("w94", 16'h0000, id.w94)
    `CHK("w100_103", 64'h0, {id.w100, id.w101, id.w102, id.w103})
    `CHK("max_lba", LN[47:0], maxl)
    `CHK("w60_61", 32'h0080_0000, {id.w61, id.w60})
    run(REV_VALUE, 16'h003f, LD, 16'h01ff, 1'b0, 10'h200);
    abrt(CYLH_REV, 8'h00);
    // Second reset clears the one-shot lock so a further set is allowed
    @(negedge clock);
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    `CHK("w83", W83_RST, id.w83)
    `CHK("max_lba", NAT, maxl)
    run(REV_VALUE, 16'h003f, LD, 16'h017f, 1'b0, 10'h280);
    abrt(8'h07, 8'h80);
    run(REV_VALUE, 16'h003f, LD, 16'h01f8, 1'b0, 10'h210);
    abrt(8'h07, 8'h01);
    // No jumper: standby bits and word 94 go
    run(REV_VALUE, 16'h003f, LD, 16'h01ef, 1'b0, 10'h200);
    `CHK("status", STAT_OK, tf.status)
    `CHK("w83", 16'h0702, id.w83)
    `CHK("w86", 16'h0702, id.w86)
    `CHK("w94", 16'h0000, id.w94)
    `CHK("w100_102", {NAT[15:0], NAT[31:16], NAT[47:32]}, {id.w100, id.w101, id.w102})
    conclude();
  end
endmodule : dco_checker_bench

// File: sim/dco_checker_monitor.sv
module dco_mon
  import dco_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_START,
  input wire dco_pkg::dco_taskfile_s O_TASKFILE,
  input wire logic O_DONE,
  input wire dco_pkg::dco_ident_s O_IDENT,
  input wire logic [47:0] O_MAX_LBA
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  property p_pulse; O_DONE |=> !O_DONE; endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_busy;
    I_START && !O_TASKFILE.busy && !O_DONE |=> O_TASKFILE.busy && O_TASKFILE.status == STAT_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_status;
    O_DONE |-> !O_TASKFILE.busy
      && O_TASKFILE.status == (O_TASKFILE.error == 8'h00 ? STAT_OK : STAT_ERR);
  endproperty
  a_status: assert property (p_status) else $error("bad completion status");
  property p_abrt; O_DONE && O_TASKFILE.error != 8'h00 |-> O_TASKFILE.error == ERR_ABRT; endproperty
  a_abrt: assert property (p_abrt) else $error("abort bit wrong");
  property p_keep;
    O_DONE && O_TASKFILE.error != 8'h00 |-> $stable(O_IDENT) && $stable(O_MAX_LBA);
  endproperty
  a_keep: assert property (p_keep) else $error("abort changed state");
  property p_quiet; !O_DONE |-> $stable(O_MAX_LBA); endproperty
  a_quiet: assert property (p_quiet) else $error("limit moved outside completion");
  property p_ok;
    O_DONE && O_TASKFILE.error == 8'h00
      |-> {O_TASKFILE.sec_num, O_TASKFILE.cyl_lo, O_TASKFILE.cyl_hi} == 24'h0;
  endproperty
  a_ok: assert property (p_ok) else $error("diagnostics set on success");
  property p_lba28;
    {O_IDENT.w61, O_IDENT.w60}
      == (O_MAX_LBA > 48'h0fffffff ? 32'h0fffffff : O_MAX_LBA[31:0]);
  endproperty
  a_lba28: assert property (p_lba28) else $error("words 60/61 wrong");
  property p_no48;
    !O_IDENT.w83[10] |-> {O_IDENT.w100, O_IDENT.w101, O_IDENT.w102, O_IDENT.w103} == 64'h0;
  endproperty
  a_no48: assert property (p_no48) else $error("48-bit words not zero");
  // Supported modes must stay a solid run from mode 0 upward
  property p_ladder; (O_IDENT.w88[5:0] & (O_IDENT.w88[5:0] + 6'h1)) == 6'h0; endproperty
  a_ladder: assert property (p_ladder) else $error("mode ladder broken");
  property p_rsvd; O_IDENT.w88[15:6] == W88_RST[15:6]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode bits moved");
endmodule : dco_mon

bind dco_checker dco_mon dco_mon_i (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_START(I_START),
  .O_TASKFILE(O_TASKFILE), .O_DONE(O_DONE), .O_IDENT(O_IDENT), .O_MAX_LBA(O_MAX_LBA));

// File: sim/dco_host_model.sv
module dco_host_model
  import dco_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic i_bad_sum,
  input wire logic [15:0] i_rev,
  input wire logic [15:0] i_udma,
  input wire logic [63:0] i_lba,
  input wire logic [15:0] i_feat,
  output logic o_start,
  output logic o_valid,
  output logic [15:0] o_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] ovl [256];
  logic [7:0] sum;
  // One process owns the outputs so each has a single driver
  initial begin
    o_start = 1'b0;
    o_valid = 1'b0;
    o_word = 16'h0;
    forever begin
      @(posedge i_go);
      for (int k = 0; k < 256; k++) ovl[k] = 16'h0;
      ovl[0] = i_rev;
      ovl[1] = 16'h0007;
      ovl[2] = i_udma;
      {ovl[6], ovl[5], ovl[4], ovl[3]} = i_lba;
      ovl[7] = i_feat;
      sum = SIGNATURE;
      for (int k = 0; k < 255; k++) sum = sum + ovl[k][7:0] + ovl[k][15:8];
      ovl[255] = {(8'h0 - sum) ^ {7'h0, i_bad_sum}, SIGNATURE};
      @(negedge i_clock);
      o_start = 1'b1;
      @(negedge i_clock);
      o_start = 1'b0;
      for (int k = 0; k < 256; k++) begin
        // A slow host leaves gaps; the idle word is scrambled so it never counts by luck
        if (i_slow && k[0]) begin
          o_valid = 1'b0;
          o_word = ~o_word;
          @(negedge i_clock);
        end
        o_valid = 1'b1;
        o_word = ovl[k];
        @(negedge i_clock);
      end
      o_valid = 1'b0;
      o_word = ~o_word;
    end
  end
endmodule : dco_host_model
